/* include/general_timer_pkg.sv */
// Constants and types shared by the general timer array
package general_timer_pkg;
  localparam int NUM_TIMERS = 4;
  localparam int CNT_W = 16;
  localparam int PRE_W = 8;
  // Timer mode encodings
  localparam logic [2:0] MODE_ONESHOT = 3'h0;
  localparam logic [2:0] MODE_PERIODIC = 3'h1;
  localparam logic [2:0] MODE_PWM = 3'h2;
  localparam logic [2:0] MODE_RTC = 3'h3;
  localparam logic [2:0] MODE_EDGE_CNT = 3'h4;
  localparam logic [2:0] MODE_EDGE_TIME = 3'h5;
  // Properties register values
  localparam logic [3:0] PROPS_SILICON = 4'h0;
  localparam logic [3:0] PROPS_INTENDED = 4'h1;
  // Reset values
  localparam logic [CNT_W-1:0] COUNT_RESET = 16'h0000;
  localparam logic [PRE_W-1:0] PRESCALE_RESET = 8'h00;
  localparam logic [CNT_W-1:0] ILR_FORBIDDEN_UP = 16'hFFFF;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_WAIT = 3'b010,
    ST_RUN = 3'b100
  } run_state_t;
endpackage

/* include/timer_chain_if.sv */
// Chain and synchronize signals between the array and one timer
interface timer_chain_if;
  logic sync_pulse;
  logic trig_in;
  logic trig_out;
  modport array_side (output sync_pulse, output trig_in, input trig_out);
  modport timer_side (input sync_pulse, input trig_in, output trig_out);
endinterface

/* hw/timer_channel.sv */
// One timer channel of the array
module timer_channel #(
  parameter int CNT_W = 16,
  parameter int PRE_W = 8
) (
  input wire logic ref_clk,
  input wire logic rst,
  timer_chain_if.timer_side chain,
  input wire logic enable,
  input wire logic [2:0] mode,
  input wire logic count_up,
  input wire logic wait_on_trigger,
  input wire logic [CNT_W-1:0] interval_load,
  input wire logic [CNT_W-1:0] match_value,
  input wire logic [PRE_W-1:0] prescale,
  input wire logic match_write,
  input wire logic prescale_write,
  input wire logic edge_in,
  output logic [CNT_W-1:0] count,
  output logic timeout
);
  logic [CNT_W-1:0] count_q, count_d;
  logic [PRE_W-1:0] pre_q, pre_d;
  logic edge_q, timeout_q, timeout_d;
  general_timer_pkg::run_state_t state_q, state_d;
  wire is_chainable = (mode == general_timer_pkg::MODE_ONESHOT) ||
                      (mode == general_timer_pkg::MODE_PERIODIC);
  wire is_pwm = mode == general_timer_pkg::MODE_PWM;
  wire is_edge_cnt = mode == general_timer_pkg::MODE_EDGE_CNT;
  wire is_edge_mode = is_edge_cnt ||
                      (mode == general_timer_pkg::MODE_EDGE_TIME);
  wire is_step_mode = is_edge_cnt || (mode == general_timer_pkg::MODE_RTC);
  wire must_wait = wait_on_trigger && is_chainable;
  wire input_edge = edge_in && !edge_q;
  wire pre_done = pre_q == prescale;
  wire tick = (state_q == general_timer_pkg::ST_RUN) &&
              (is_edge_mode ? input_edge : pre_done);
  wire reg_step = enable && is_step_mode && (match_write || prescale_write);
  wire at_end = count_up ? (count_q == interval_load) :
                (count_q == general_timer_pkg::COUNT_RESET);
  // Edge count up: match seen, one more edge wraps to zero
  wire ec_hit = is_edge_cnt && count_up && (count_q == match_value);
  wire [CNT_W-1:0] reload = count_up ? general_timer_pkg::COUNT_RESET :
                            interval_load;
  wire [CNT_W-1:0] stepped = count_up ? count_q + 1'b1 : count_q - 1'b1;

  always_comb begin
    state_d = state_q;
    unique case (state_q)
      general_timer_pkg::ST_IDLE:
        if (enable) begin
          state_d = must_wait ? general_timer_pkg::ST_WAIT
                              : general_timer_pkg::ST_RUN;
        end
      general_timer_pkg::ST_WAIT:
        if (!enable) begin
          state_d = general_timer_pkg::ST_IDLE;
        end else if (chain.trig_in) begin
          state_d = general_timer_pkg::ST_RUN;
        end
      general_timer_pkg::ST_RUN:
        if (!enable) begin
          state_d = general_timer_pkg::ST_IDLE;
        end else if (tick && at_end &&
                     mode == general_timer_pkg::MODE_ONESHOT) begin
          state_d = general_timer_pkg::ST_IDLE;
        end
    endcase
  end

  always_comb begin
    count_d = count_q;
    pre_d = pre_q;
    timeout_d = 1'b0;
    if (state_q != general_timer_pkg::ST_RUN) begin
      pre_d = general_timer_pkg::PRESCALE_RESET;
    end else if (!is_edge_mode) begin
      pre_d = pre_done ? general_timer_pkg::PRESCALE_RESET
                       : pre_q + 1'b1;
    end
    if (chain.sync_pulse) begin
      count_d = reload;
      pre_d = general_timer_pkg::PRESCALE_RESET;
    end else if (reg_step) begin
      count_d = stepped;
    end else if (state_q == general_timer_pkg::ST_IDLE && !enable) begin
      count_d = reload;
    end else if (tick) begin
      if (is_edge_cnt && count_up) begin
        count_d = ec_hit ? general_timer_pkg::COUNT_RESET : stepped;
        timeout_d = stepped == match_value;
      end else if (at_end) begin
        count_d = reload;
        timeout_d = 1'b1;
      end else begin
        count_d = stepped;
      end
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      state_q <= general_timer_pkg::ST_IDLE;
      count_q <= general_timer_pkg::COUNT_RESET;
      pre_q <= general_timer_pkg::PRESCALE_RESET;
      edge_q <= 1'b0;
      timeout_q <= 1'b0;
    end else begin
      state_q <= state_d;
      count_q <= count_d;
      pre_q <= pre_d;
      edge_q <= edge_in;
      timeout_q <= timeout_d;
    end
  end

  assign count = count_q;
  assign timeout = timeout_q;
  // A PWM timer never emits a chain trigger
  assign chain.trig_out = timeout_q && is_chainable;

  a_pwm_no_wait: assert property (@(posedge ref_clk) disable iff (rst)
    state_q == general_timer_pkg::ST_IDLE && enable && is_pwm
    |=> state_q == general_timer_pkg::ST_RUN)
    else $error("PWM timer waited for chain trigger");
  a_wait_holds: assert property (@(posedge ref_clk) disable iff (rst)
    state_q == general_timer_pkg::ST_WAIT && enable && !chain.trig_in
    |=> state_q == general_timer_pkg::ST_WAIT)
    else $error("Timer left wait without trigger");
  a_reg_step: assert property (@(posedge ref_clk) disable iff (rst)
    reg_step && !chain.sync_pulse |=> count_q == $past(stepped))
    else $error("Register write did not step counter");
endmodule // timer_channel

/* hw/general_timer_array.sv */
// Array of general timers with synchronize and daisy chain
////////////////////////////////////////////////////////////////////////////
// Summary of operation
// - Synchronize bits restart selected timers together
// - Synchronize bits stay set; software clears them
// - Properties register reads zero, narrow class
// - Chain trigger honoured in one-shot/periodic only
// - PWM with wait bit starts immediately
// - Waiting on a PWM timer never starts
// - Sync ignored if any target RTC/edge-count
// - Match/prescale write steps enabled RTC/edge-count counter
// - Edge-count up needs one extra edge to wrap
module general_timer_array #(
  parameter int NUM_TIMERS = general_timer_pkg::NUM_TIMERS,
  parameter int CNT_W = general_timer_pkg::CNT_W,
  parameter int PRE_W = general_timer_pkg::PRE_W
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [NUM_TIMERS-1:0] timer_sync_wr,
  input wire logic [NUM_TIMERS-1:0] timer_sync_wdata,
  output logic [NUM_TIMERS-1:0] timer_sync_reg,
  output logic [3:0] timer_properties_reg,
  input wire logic [NUM_TIMERS-1:0] enable,
  input wire logic [NUM_TIMERS*3-1:0] timer_mode_reg,
  input wire logic [NUM_TIMERS-1:0] count_up,
  input wire logic [NUM_TIMERS-1:0] wait_on_trigger,
  input wire logic [NUM_TIMERS*CNT_W-1:0] interval_load_reg,
  input wire logic [NUM_TIMERS*CNT_W-1:0] match_value_reg,
  input wire logic [NUM_TIMERS*PRE_W-1:0] prescale_reg,
  input wire logic [NUM_TIMERS-1:0] match_write,
  input wire logic [NUM_TIMERS-1:0] prescale_write,
  input wire logic [NUM_TIMERS-1:0] edge_in,
  output logic [NUM_TIMERS*CNT_W-1:0] count,
  output logic [NUM_TIMERS-1:0] timeout
);
  logic [NUM_TIMERS-1:0] sync_q, sync_d;
  logic [NUM_TIMERS-1:0] sync_rise;
  logic [NUM_TIMERS-1:0] blocked_mode;
  logic [NUM_TIMERS-1:0] trig_chain;
  timer_chain_if chain_if [NUM_TIMERS] ();

  ////////////////////////////////////////////////////////////////////////////
  // Synchronize register, bits never self clear
  assign sync_d = (sync_q & ~timer_sync_wr) |
                  (timer_sync_wdata & timer_sync_wr);
  assign sync_rise = sync_d & ~sync_q;
  // Any selected timer in RTC or edge-count blocks the whole request
  wire sync_blocked = |(sync_rise & blocked_mode);
  wire [NUM_TIMERS-1:0] sync_fire = sync_blocked ? '0 : sync_rise;

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      sync_q <= '0;
    end else begin
      sync_q <= sync_d;
    end
  end

  assign timer_sync_reg = sync_q;
  assign timer_properties_reg = general_timer_pkg::PROPS_SILICON;

  ////////////////////////////////////////////////////////////////////////////
  // Timer channels and daisy chain
  for (genvar i = 0; i < NUM_TIMERS; i++) begin : g_timer
    wire [2:0] mode_i = timer_mode_reg[i*3 +: 3];
    assign blocked_mode[i] = (mode_i == general_timer_pkg::MODE_RTC) ||
                             (mode_i == general_timer_pkg::MODE_EDGE_CNT);
    assign trig_chain[i] = chain_if[i].trig_out;
    assign chain_if[i].sync_pulse = sync_fire[i];
    if (i == 0) begin : g_first
      assign chain_if[i].trig_in = 1'b0;
    end else begin : g_next
      assign chain_if[i].trig_in = trig_chain[i-1];
    end
    timer_channel #(.CNT_W(CNT_W), .PRE_W(PRE_W)) u_timer (
      .ref_clk(ref_clk),
      .rst(rst),
      .chain(chain_if[i]),
      .enable(enable[i]),
      .mode(mode_i),
      .count_up(count_up[i]),
      .wait_on_trigger(wait_on_trigger[i]),
      .interval_load(interval_load_reg[i*CNT_W +: CNT_W]),
      .match_value(match_value_reg[i*CNT_W +: CNT_W]),
      .prescale(prescale_reg[i*PRE_W +: PRE_W]),
      .match_write(match_write[i]),
      .prescale_write(prescale_write[i]),
      .edge_in(edge_in[i]),
      .count(count[i*CNT_W +: CNT_W]),
      .timeout(timeout[i])
    );
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  a_sync_sticky: assert property (@(posedge ref_clk) disable iff (rst)
    sync_q != 0 && timer_sync_wr == 0 |=> sync_q == $past(sync_q))
    else $error("Synchronize bits cleared themselves");
  a_sync_blocked: assert property (@(posedge ref_clk) disable iff (rst)
    |(sync_rise & blocked_mode) |-> sync_fire == 0)
    else $error("Synchronize acted despite RTC or edge-count timer");
  a_props_zero: assert property (@(posedge ref_clk) disable iff (rst)
    timer_properties_reg != general_timer_pkg::PROPS_INTENDED)
    else $error("Properties register reports wide class");
endmodule // general_timer_array

/* tb/general_timer_array_test.sv */
// Self-checking bench for the general timer array
module general_timer_array_test;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int N = general_timer_pkg::NUM_TIMERS;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic [N-1:0] sync_wr = '0, sync_wd = '0, en = '0, up = '0, wot = '0;
  logic [N-1:0] mwr = '0, pwr = '0, edge_in = '0;
  logic [N*3-1:0] mode = '0;
  logic [N*16-1:0] ilr = '0, mvr = '0;
  logic [N*8-1:0] pre = '0;
  logic [N-1:0] sync_q, tout;
  logic [3:0] props;
  logic [N*16-1:0] cnt_o;
  int failures = 0;
  int check_count = 0;
  int touts = 0;
  always #5 ref_clk = ~ref_clk;
  always @(posedge ref_clk) if (tout[3] === 1'b1) touts <= touts + 1;
  general_timer_array uut (.ref_clk(ref_clk), .rst(rst),
    .timer_sync_wr(sync_wr), .timer_sync_wdata(sync_wd),
    .timer_sync_reg(sync_q), .timer_properties_reg(props), .enable(en),
    .timer_mode_reg(mode), .count_up(up), .wait_on_trigger(wot),
    .interval_load_reg(ilr), .match_value_reg(mvr), .prescale_reg(pre),
    .match_write(mwr), .prescale_write(pwr), .edge_in(edge_in),
    .count(cnt_o), .timeout(tout));
  ////////////////////////////////////////////////////////////////////////
  task summarize;
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task chk16(input logic [15:0] got, input logic [15:0] exp, input string m);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED %0t %s", $time, m);
    end
  endtask
  task chk4(input logic [3:0] got, input logic [3:0] exp, input string m);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED %0t %s", $time, m);
    end
  endtask
  task cyc(input int n);
    repeat (n) @(negedge ref_clk);
  endtask
  function automatic logic [15:0] c(input int i);
    return cnt_o[i*16+:16];
  endfunction
  task do_reset;
    rst = 1'b1;
    en = '0;
    mode = '0;
    mvr = '0;
    cyc(8);
    rst = 1'b0;
  endtask
  task setup(input int i, input logic [2:0] m, input logic u, input logic w,
             input logic [15:0] il);
    mode[i*3+:3] = m;
    up[i] = u;
    wot[i] = w;
    ilr[i*16+:16] = il;
  endtask
  task sync_write(input logic [N-1:0] wr, input logic [N-1:0] wd);
    sync_wr = wr;
    sync_wd = wd;
    cyc(1);
    sync_wr = '0;
  endtask
  task pulse_edge(input int i);
    edge_in[i] = 1'b1;
    cyc(3);
    edge_in[i] = 1'b0;
    cyc(3);
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    #200000;
    failures++;
    summarize;
  end
  initial begin
    cyc(8);
    rst = 1'b0;
    chk4(sync_q, 4'h0, "sync bits after reset");
    chk4(props, general_timer_pkg::PROPS_SILICON, "properties");
    // Lockstep restart of two staggered timers
    setup(0, general_timer_pkg::MODE_PERIODIC, 1'b0, 1'b0, 16'h0100);
    setup(1, general_timer_pkg::MODE_PERIODIC, 1'b0, 1'b0, 16'h0100);
    en[0] = 1'b1;
    cyc(5);
    en[1] = 1'b1;
    cyc(2);
    sync_write(4'h3, 4'h3);
    cyc(3);
    chk16(c(1), c(0), "timers not in lockstep");
    cyc(20);
    chk4(sync_q, 4'h3, "sync bits cleared themselves");
    sync_write(4'hF, 4'h0);
    chk4(sync_q, 4'h0, "sync bits not cleared by write");
    // Sync refused with an RTC target
    setup(2, general_timer_pkg::MODE_RTC, 1'b1, 1'b0, 16'h0100);
    en[2] = 1'b1;
    cyc(3);
    sync_write(4'h5, 4'h5);
    cyc(3);
    chk16(c(0), c(1), "sync acted with RTC target");
    ////////////////////////////////////////////////////////////////////
    // Edge count up with match 3, then register-write steps
    do_reset;
    setup(3, general_timer_pkg::MODE_EDGE_CNT, 1'b1, 1'b0, 16'h0000);
    mvr[48+:16] = 16'h0003;
    en[3] = 1'b1;
    cyc(2);
    for (int k = 1; k <= 7; k++) begin
      pulse_edge(3);
      chk16(c(3), 16'(k % 4), "edge count value");
    end
    chk4(touts[3:0], 4'h2, "edge count timeouts");
    setup(2, general_timer_pkg::MODE_EDGE_CNT, 1'b0, 1'b0, 16'h0010);
    setup(1, general_timer_pkg::MODE_EDGE_CNT, 1'b1, 1'b0, 16'h0010);
    // Idle disabled cycle loads the new reload value
    cyc(1);
    en[2] = 1'b1;
    cyc(2);
    pwr[2:1] = 2'b11;
    cyc(1);
    pwr[2:1] = 2'b00;
    mwr[2] = 1'b1;
    cyc(1);
    mwr[2] = 1'b0;
    cyc(2);
    chk16(c(2), 16'h000E, "write steps down");
    chk16(c(1), 16'h0000, "disabled timer stepped");
    ////////////////////////////////////////////////////////////////////
    // Chain behind a PWM timer, and PWM with the wait bit
    do_reset;
    setup(0, general_timer_pkg::MODE_PWM, 1'b0, 1'b0, 16'h0008);
    setup(1, general_timer_pkg::MODE_PERIODIC, 1'b0, 1'b1, 16'h0040);
    setup(2, general_timer_pkg::MODE_PWM, 1'b0, 1'b1, 16'h0040);
    setup(3, general_timer_pkg::MODE_EDGE_TIME, 1'b1, 1'b0, 16'h1000);
    cyc(1);
    en = 4'hF;
    cyc(100);
    chk16(c(1), 16'h0040, "started behind PWM timer");
    chk4({3'b0, c(2) != 16'h0040}, 4'h1, "PWM waited");
    // Chain behind a periodic timer
    do_reset;
    setup(0, general_timer_pkg::MODE_PERIODIC, 1'b0, 1'b0, 16'h0020);
    setup(1, general_timer_pkg::MODE_ONESHOT, 1'b0, 1'b1, 16'h0040);
    cyc(1);
    en = 4'h3;
    cyc(10);
    chk16(c(1), 16'h0040, "started before trigger");
    for (int k = 0; k <= 500; k++) begin
      if (k == 500) begin
        failures++;
        summarize;
      end
      cyc(1);
      if (tout[0] === 1'b1) break;
    end
    cyc(4);
    chk4({3'b0, c(1) != 16'h0040}, 4'h1, "no start on trigger");
    summarize;
  end
endmodule // general_timer_array_test
